// File: rtl/instruction_cycle_timing.sv
// Instruction cycle sequencer: spends fetch, read, write and internal cycles
// per instruction class. Decode supplies one descriptor per instruction;
// cache, write buffer and external bus report through mem_status_t.
//
// How it works
// - Failed condition: one fetch only
// - Data processing: fetch, +1 internal if reg shift, PC three
// - Load word: fetch, read, internal; PC three
// - Store word: fetch then one write
// - Load multiple: fetch, n reads, internal
// - Store multiple: fetch then n writes
// - Swap: fetch, read, write, internal
// - Multiply: fetch plus m internal cycles
// - Small multipliers terminate early after m
// - Zero/one takes one; large takes sixteen
// - Coprocessor ops trap except CP15 moves, reg 0-7
// - CP15 moves: fetch plus three internal
// - Internal cycle is exactly one clock
// - Hit one clock; miss external access
// - Write one clock if buffer room
// - Buffer disabled: write goes external
// - Cacheable miss fills line; maybe walk
// - Execute, decode and fetch overlap
module instruction_cycle_timing (
	input  wire logic                           clk,           // Core fast clock
	input  wire logic                           rst_n,         // Async reset, low
	input  wire cycle_timing_pkg::instr_desc_t  decoded,       // Descriptor in decode
	input  wire logic                           decoded_valid, // Decode holds one
	input  wire cycle_timing_pkg::mem_status_t  mem_status,    // Memory side status
	output cycle_timing_pkg::cycle_kind_t       cycle_kind,    // Current cycle kind
	output logic                                accept,        // Descriptor taken
	output logic                                undef_trap,    // Undefined trap entry
	output logic                                instr_done,    // Instruction retired
	output cycle_timing_pkg::mem_request_t      mem_request,   // Memory requests
	output logic                                busy           // Sequencer executing
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FETCH,
		ST_READ,
		ST_WRITE,
		ST_INTERNAL
	} seq_state_t;

	seq_state_t                   state;        // Current phase
	logic [4:0]                   fetch_left;   // Fetch cycles still owed
	logic [4:0]                   read_left;    // Data reads still owed
	logic [4:0]                   write_left;   // Data writes still owed
	logic [4:0]                   intern_left;  // Internal cycles still owed
	logic [4:0]                   mul_cycles;   // Multiply count from helper
	logic                         trap_taken;   // This instruction traps
	logic                         mem_wait;     // Memory cycle stalled

	logic [4:0]                   n_fetch;      // Plan for incoming descriptor
	logic [4:0]                   n_read;
	logic [4:0]                   n_write;
	logic [4:0]                   n_intern;
	logic                         n_trap;

	multiply_cycle_count u_mul (
		.multiplier (decoded.multiplier),
		.cycles     (mul_cycles)
	);

	// Coprocessor ops legal only as CP15 register moves 0..7
	function automatic logic coproc_traps(input cycle_timing_pkg::instr_desc_t d);
		logic legal;
		legal = (d.class_code == cycle_timing_pkg::CLS_COPROC_MOVE)
			&& (d.coproc_num == cycle_timing_pkg::INTERNAL_COPROC)
			&& (d.coproc_reg <= cycle_timing_pkg::COPROC_REG_LIMIT);
		return !legal;
	endfunction

	// Fetch count: refill when the program counter is written
	function automatic logic [4:0] fetches(input logic pc_wr);
		return pc_wr ? cycle_timing_pkg::PC_REFILL_FETCHES : cycle_timing_pkg::ONE_CYCLE;
	endfunction

	// Work out the cycle budget for the descriptor now in decode
	always_comb
	begin
		n_fetch  = cycle_timing_pkg::ONE_CYCLE;
		n_read   = 5'h00;
		n_write  = 5'h00;
		n_intern = 5'h00;
		n_trap   = 1'b0;
		if (!decoded.cond_pass)
		begin
			n_fetch = cycle_timing_pkg::ONE_CYCLE;
		end
		else
		begin
			case (decoded.class_code)
				cycle_timing_pkg::CLS_DATA_PROC:
				begin
					n_fetch  = fetches(decoded.pc_written);
					n_intern = decoded.reg_shift ? cycle_timing_pkg::ONE_CYCLE : 5'h00;
				end
				cycle_timing_pkg::CLS_PSR_XFER:
				begin
					n_fetch = cycle_timing_pkg::ONE_CYCLE;
				end
				cycle_timing_pkg::CLS_LOAD_WORD:
				begin
					n_fetch  = fetches(decoded.pc_written);
					n_read   = cycle_timing_pkg::ONE_CYCLE;
					n_intern = cycle_timing_pkg::ONE_CYCLE;
				end
				cycle_timing_pkg::CLS_STORE_WORD:
				begin
					n_write = cycle_timing_pkg::ONE_CYCLE;
				end
				cycle_timing_pkg::CLS_LOAD_MULTIPLE:
				begin
					n_fetch  = fetches(decoded.pc_written);
					n_read   = decoded.word_count;
					n_intern = cycle_timing_pkg::ONE_CYCLE;
				end
				cycle_timing_pkg::CLS_STORE_MULTIPLE:
				begin
					n_write = decoded.word_count;
				end
				cycle_timing_pkg::CLS_ATOMIC_SWAP:
				begin
					n_read   = cycle_timing_pkg::ONE_CYCLE;
					n_write  = cycle_timing_pkg::ONE_CYCLE;
					n_intern = cycle_timing_pkg::ONE_CYCLE;
				end
				cycle_timing_pkg::CLS_BRANCH,
				cycle_timing_pkg::CLS_SOFTWARE_INTERRUPT:
				begin
					n_fetch = cycle_timing_pkg::PC_REFILL_FETCHES;
				end
				cycle_timing_pkg::CLS_MULTIPLY:
				begin
					n_intern = mul_cycles;
				end
				cycle_timing_pkg::CLS_COPROC_MOVE:
				begin
					n_trap   = coproc_traps(decoded);
					n_fetch  = n_trap ? cycle_timing_pkg::PC_REFILL_FETCHES
						: cycle_timing_pkg::ONE_CYCLE;
					n_intern = n_trap ? 5'h00 : cycle_timing_pkg::COPROC_INTERNALS;
				end
				default:
				begin
					// Data op, coprocessor load/store, undefined: trap entry
					n_trap  = 1'b1;
					n_fetch = cycle_timing_pkg::PC_REFILL_FETCHES;
				end
			endcase
		end
	end

	// Fetch and read stall on a miss until the external access ends
	// Write stalls on full buffer, or goes external when buffer is off
	always_comb
	begin
		mem_wait = 1'b0;
		case (state)
			ST_FETCH,
			ST_READ:
			begin
				mem_wait = !mem_status.cache_hit && !mem_status.ext_done;
			end
			ST_WRITE:
			begin
				if (mem_status.wbuf_enabled)
				begin
					mem_wait = !mem_status.wbuf_space;
				end
				else
				begin
					mem_wait = !mem_status.ext_done;
				end
			end
			default:
			begin
				mem_wait = 1'b0;
			end
		endcase
	end

	// Phase sequencing: fetch, reads, writes, then internal cycles.
	// The next descriptor is taken during the last cycle so decode
	// and fetch of the following instruction overlap this one.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state       <= ST_IDLE;
			fetch_left  <= 5'h00;
			read_left   <= 5'h00;
			write_left  <= 5'h00;
			intern_left <= 5'h00;
			trap_taken  <= 1'b0;
		end
		else if (state == ST_IDLE || (last_cycle() && !mem_wait))
		begin
			if (decoded_valid)
			begin
				state       <= ST_FETCH;
				fetch_left  <= n_fetch;
				read_left   <= n_read;
				write_left  <= n_write;
				intern_left <= n_intern;
				trap_taken  <= n_trap;
			end
			else
			begin
				state <= ST_IDLE;
			end
		end
		else if (!mem_wait)
		begin
			case (state)
				ST_FETCH:
				begin
					fetch_left <= fetch_left - 5'h01;
					if (fetch_left == 5'h01)
					begin
						state <= next_phase(read_left, write_left);
					end
				end
				ST_READ:
				begin
					read_left <= read_left - 5'h01;
					if (read_left == 5'h01)
					begin
						state <= (write_left != 5'h00) ? ST_WRITE : ST_INTERNAL;
					end
				end
				ST_WRITE:
				begin
					write_left <= write_left - 5'h01;
					if (write_left == 5'h01)
					begin
						state <= ST_INTERNAL;
					end
				end
				ST_INTERNAL:
				begin
					intern_left <= intern_left - 5'h01;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Phase after fetching
	function automatic seq_state_t next_phase(input logic [4:0] rd, input logic [4:0] wr);
		if (rd != 5'h00)
		begin
			return ST_READ;
		end
		else if (wr != 5'h00)
		begin
			return ST_WRITE;
		end
		return ST_INTERNAL;
	endfunction

	// True in the final cycle of the current instruction
	function automatic logic last_cycle();
		case (state)
			ST_FETCH:    return fetch_left == 5'h01 && read_left == 5'h00
				&& write_left == 5'h00 && intern_left == 5'h00;
			ST_READ:     return read_left == 5'h01 && write_left == 5'h00
				&& intern_left == 5'h00;
			ST_WRITE:    return write_left == 5'h01 && intern_left == 5'h00;
			ST_INTERNAL: return intern_left == 5'h01;
			default:     return 1'b0;
		endcase
	endfunction

	// Registered outputs reflecting the previous cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cycle_kind  <= cycle_timing_pkg::CYC_IDLE;
			accept      <= 1'b0;
			undef_trap  <= 1'b0;
			instr_done  <= 1'b0;
			busy        <= 1'b0;
		end
		else
		begin
			accept     <= decoded_valid && (state == ST_IDLE || (last_cycle() && !mem_wait));
			undef_trap <= decoded_valid && n_trap
				&& (state == ST_IDLE || (last_cycle() && !mem_wait));
			instr_done <= state != ST_IDLE && last_cycle() && !mem_wait;
			busy       <= state != ST_IDLE;
			case (state)
				ST_FETCH:    cycle_kind <= cycle_timing_pkg::CYC_FETCH;
				ST_READ:     cycle_kind <= cycle_timing_pkg::CYC_READ;
				ST_WRITE:    cycle_kind <= cycle_timing_pkg::CYC_WRITE;
				ST_INTERNAL: cycle_kind <= cycle_timing_pkg::CYC_INTERNAL;
				default:     cycle_kind <= cycle_timing_pkg::CYC_IDLE;
			endcase
		end
	end

	// Memory side requests; a miss in cacheable space asks for a line fill
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_request <= '0;
		end
		else
		begin
			mem_request.ext_access <= mem_wait;
			mem_request.line_fill  <= (state == ST_FETCH || state == ST_READ)
				&& !mem_status.cache_hit && mem_status.cacheable;
			mem_request.table_walk <= (state != ST_IDLE && state != ST_INTERNAL)
				&& mem_status.walk_needed;
			mem_request.wbuf_push  <= state == ST_WRITE && mem_status.wbuf_enabled
				&& mem_status.wbuf_space;
		end
	end

endmodule

// File: rtl/cycle_timing_pkg.sv
// Shared types and constants for the instruction cycle sequencer.
// Assumes a single clock domain; all users write cycle_timing_pkg::name.
package cycle_timing_pkg;

	// Instruction classes as seen by the sequencer
	typedef enum logic [3:0] {
		CLS_DATA_PROC,
		CLS_PSR_XFER,
		CLS_LOAD_WORD,
		CLS_STORE_WORD,
		CLS_LOAD_MULTIPLE,
		CLS_STORE_MULTIPLE,
		CLS_ATOMIC_SWAP,
		CLS_BRANCH,
		CLS_SOFTWARE_INTERRUPT,
		CLS_MULTIPLY,
		CLS_COPROC_DATA_OP,
		CLS_COPROC_LOAD,
		CLS_COPROC_STORE,
		CLS_COPROC_MOVE,
		CLS_UNDEFINED
	} instr_class_t;

	// Kind of a single sequencer cycle
	typedef enum logic [2:0] {
		CYC_IDLE,
		CYC_FETCH,
		CYC_READ,
		CYC_WRITE,
		CYC_INTERNAL
	} cycle_kind_t;

	// Decoded instruction descriptor handed over by decode
	typedef struct packed {
		instr_class_t class_code;   // Instruction class
		logic         cond_pass;    // Condition evaluated true
		logic         reg_shift;    // Shift amount from a register
		logic         pc_written;   // Program counter is a destination
		logic [4:0]   word_count;   // Words for multiple transfers, 1..16
		logic [31:0]  multiplier;   // Value of multiplier_register
		logic [3:0]   coproc_num;   // Target coprocessor
		logic [3:0]   coproc_reg;   // Coprocessor register number
	} instr_desc_t;

	// Memory cycle status from cache and write buffer
	typedef struct packed {
		logic cache_hit;          // Access hit in the cache
		logic cacheable;          // Region marked cacheable
		logic walk_needed;        // Translation table walk required
		logic wbuf_enabled;       // Write buffer switched on
		logic wbuf_space;         // Write buffer has room
		logic ext_done;           // External access finished this cycle
	} mem_status_t;

	// Request to the memory side
	typedef struct packed {
		logic ext_access;         // Full external access in progress
		logic line_fill;          // Cache line fill wanted
		logic table_walk;         // Table walk wanted
		logic wbuf_push;          // Write placed in write buffer
	} mem_request_t;

	localparam logic [3:0]  INTERNAL_COPROC     = 4'h000f;
	localparam logic [3:0]  COPROC_REG_LIMIT    = 4'h0007;
	localparam logic [4:0]  PC_REFILL_FETCHES   = 5'h0003;
	localparam logic [4:0]  COPROC_INTERNALS    = 5'h0003;
	localparam logic [4:0]  MULTIPLY_MAX_CYCLES = 5'h0010;
	localparam logic [4:0]  ONE_CYCLE           = 5'h0001;

endpackage

// File: rtl/multiply_cycle_count.sv
// Early-termination cycle count for multiply from the multiplier value.
// Purely combinational; driven by the sequencer on the same clock.
module multiply_cycle_count (
	input  wire logic [31:0] multiplier,  // multiplier_register value
	output logic      [4:0]  cycles       // Internal cycles needed, 1..16
);

	// Highest set bit picks m: value below 2^(2m-1) finishes in m cycles
	always_comb
	begin
		cycles = cycle_timing_pkg::ONE_CYCLE;
		for (int i = 2; i <= 16; i++)
		begin
			// Any bit at or above 2^(2i-3) pushes the count to i
			if ((multiplier >> (2 * i - 3)) != 32'h0000_0000)
			begin
				cycles = 5'(i);
			end
		end
	end

endmodule

// File: verification/instruction_cycle_timing_assertions.sv
// Port checker for the cycle sequencer, bound into its top module.
// Counted shapes assume a hit and buffer room when the step starts.
module instruction_cycle_timing_assertions (
	input wire logic                           clk,
	input wire logic                           rst_n,
	input wire cycle_timing_pkg::instr_desc_t  decoded,
	input wire logic                           decoded_valid,
	input wire cycle_timing_pkg::mem_status_t  mem_status,
	input wire cycle_timing_pkg::cycle_kind_t  cycle_kind,
	input wire logic                           accept,
	input wire logic                           undef_trap,
	input wire logic                           instr_done,
	input wire cycle_timing_pkg::mem_request_t mem_request,
	input wire logic                           busy
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam cycle_timing_pkg::cycle_kind_t F = cycle_timing_pkg::CYC_FETCH;    // Fetch
	localparam cycle_timing_pkg::cycle_kind_t R = cycle_timing_pkg::CYC_READ;     // Read
	localparam cycle_timing_pkg::cycle_kind_t W = cycle_timing_pkg::CYC_WRITE;    // Write
	localparam cycle_timing_pkg::cycle_kind_t I = cycle_timing_pkg::CYC_INTERNAL; // Internal
	cycle_timing_pkg::instr_desc_t p;  // Descriptor that accept answers for
	logic                          t;  // Executed instruction taken
	logic                          q;  // Memory answering at once
	logic                          cp; // Taken class must trap
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// Decode holds the descriptor until accept, so one stage back is enough
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			p <= '0;
		else
			p <= decoded;
	end
	assign t = accept && p.cond_pass;
	assign q = mem_status.cache_hit && mem_status.wbuf_space;
	// Coprocessor work traps unless it moves low internal registers
	assign cp = p.class_code inside {cycle_timing_pkg::CLS_COPROC_DATA_OP,
		cycle_timing_pkg::CLS_COPROC_LOAD, cycle_timing_pkg::CLS_COPROC_STORE,
		cycle_timing_pkg::CLS_UNDEFINED} || (p.class_code == cycle_timing_pkg::CLS_COPROC_MOVE
		&& (p.coproc_num != cycle_timing_pkg::INTERNAL_COPROC
		|| p.coproc_reg > cycle_timing_pkg::COPROC_REG_LIMIT));
	property p_skip;
		accept && !p.cond_pass && q |=> cycle_kind == F && instr_done;
	endproperty
	a_skip: assert property (p_skip)
		else $error("skipped step not one fetch");
	property p_trap;
		accept |-> undef_trap == (t && cp);
	endproperty
	a_trap: assert property (p_trap)
		else $error("trap decision wrong");
	property p_refill;
		undef_trap && q |=> (cycle_kind == F) [*3] ##0 instr_done;
	endproperty
	a_refill: assert property (p_refill)
		else $error("trap entry not three fetches");
	property p_cp15;
		t && !cp && p.class_code == cycle_timing_pkg::CLS_COPROC_MOVE && q
			|=> cycle_kind == F ##1 (cycle_kind == I) [*3] ##0 instr_done;
	endproperty
	a_cp15: assert property (p_cp15)
		else $error("internal move shape wrong");
	property p_str;
		t && p.class_code == cycle_timing_pkg::CLS_STORE_WORD && q
			|=> cycle_kind == F ##1 cycle_kind == W && instr_done;
	endproperty
	a_str: assert property (p_str)
		else $error("store shape wrong");
	property p_ldr;
		t && p.class_code == cycle_timing_pkg::CLS_LOAD_WORD && !p.pc_written && q
			|=> cycle_kind == F ##1 cycle_kind == R ##1 cycle_kind == I && instr_done;
	endproperty
	a_ldr: assert property (p_ldr)
		else $error("load shape wrong");
	property p_swp;
		t && p.class_code == cycle_timing_pkg::CLS_ATOMIC_SWAP && q |=> cycle_kind == F
			##1 cycle_kind == R ##1 cycle_kind == W ##1 cycle_kind == I && instr_done;
	endproperty
	a_swp: assert property (p_swp)
		else $error("swap shape wrong");
	property p_mul;
		t && p.class_code == cycle_timing_pkg::CLS_MULTIPLY && p.multiplier < 32'h0000_0002
			&& q |=> cycle_kind == F ##1 cycle_kind == I && instr_done;
	endproperty
	a_mul: assert property (p_mul)
		else $error("short multiply shape wrong");
endmodule

bind instruction_cycle_timing instruction_cycle_timing_assertions u_check (
	.clk(clk), .rst_n(rst_n), .decoded(decoded), .decoded_valid(decoded_valid),
	.mem_status(mem_status), .cycle_kind(cycle_kind), .accept(accept),
	.undef_trap(undef_trap), .instr_done(instr_done), .mem_request(mem_request),
	.busy(busy)
);

// File: verification/mem_model.sv
// Memory side model: cache, write buffer and external bus status.
// Assumes mem_request is the sequencer's registered request.
module mem_model #(
	parameter int LAT = 3 // External access length in cycles
) (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           slow,  // Miss and bypass when high
	input  wire cycle_timing_pkg::mem_request_t req,
	output cycle_timing_pkg::mem_status_t       st
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt; // Cycles of the running external access
	// Count the external access, restart after each completion
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt <= 0;
		else if (req.ext_access && !st.ext_done)
			cnt <= cnt + 1;
		else
			cnt <= 0;
	end
	// Slow mode never hits, so every access has to go outside
	always_comb
	begin
		st.cache_hit    = !slow;
		st.cacheable    = 1'b1;
		st.walk_needed  = slow;
		st.wbuf_enabled = !slow;
		st.wbuf_space   = !slow;
		st.ext_done     = slow && (cnt == LAT);
	end
endmodule

// File: verification/tb.sv
// Bench for the cycle sequencer against the memory side model.
// Assumes the sequencer is idle when each table row is offered.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Class, cond/shift/pc bits, words, multiplier, coproc, reg, F R W I, trap
	typedef struct {
		int c; int x; int n; logic [31:0] m; int cp; int cr;
		int f; int r; int w; int i; int t;
	} row_t;
	logic                           clk;        // Core clock
	logic                           rst_n;      // Reset, low
	logic                           slow;       // Memory misses
	logic                           valid;      // Descriptor offered
	cycle_timing_pkg::instr_desc_t  decoded;    // Descriptor
	cycle_timing_pkg::mem_status_t  st;         // Memory status
	cycle_timing_pkg::mem_request_t req;        // Memory request
	cycle_timing_pkg::cycle_kind_t  kind;       // Cycle kind
	logic                           accept;     // Taken pulse
	logic                           undef_trap; // Trap pulse
	logic                           instr_done; // Retire pulse
	logic                           busy;       // Executing
	int                             err_count;  // Mismatches
	int                             n_tests;    // Comparisons
	int                             cnt [5];    // Cycles per kind
	int                             a;          // Accepts seen
	int                             d;          // Retires seen
	int                             n;          // Busy cycles seen
	int                             k;          // Wait bound
	row_t                           rows [27] = '{
		'{3, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0},
		'{10, 0, 0, 0, 0, 0, 1, 0, 0, 0, 0},
		'{0, 4, 0, 0, 0, 0, 1, 0, 0, 0, 0},
		'{0, 6, 0, 0, 0, 0, 1, 0, 0, 1, 0},
		'{0, 5, 0, 0, 0, 0, 3, 0, 0, 0, 0},
		'{0, 7, 0, 0, 0, 0, 3, 0, 0, 1, 0},
		'{2, 4, 0, 0, 0, 0, 1, 1, 0, 1, 0},
		'{2, 5, 0, 0, 0, 0, 3, 1, 0, 1, 0},
		'{3, 4, 0, 0, 0, 0, 1, 0, 1, 0, 0},
		'{4, 4, 1, 0, 0, 0, 1, 1, 0, 1, 0},
		'{4, 5, 16, 0, 0, 0, 3, 16, 0, 1, 0},
		'{5, 4, 16, 0, 0, 0, 1, 0, 16, 0, 0},
		'{6, 4, 0, 0, 0, 0, 1, 1, 1, 1, 0},
		'{7, 4, 0, 0, 0, 0, 3, 0, 0, 0, 0},
		'{8, 4, 0, 0, 0, 0, 3, 0, 0, 0, 0},
		'{9, 4, 0, 0, 0, 0, 1, 0, 0, 1, 0},
		'{9, 4, 0, 7, 0, 0, 1, 0, 0, 2, 0},
		'{9, 4, 0, 8, 0, 0, 1, 0, 0, 3, 0},
		'{9, 4, 0, 32'h1fff_ffff, 0, 0, 1, 0, 0, 15, 0},
		'{9, 4, 0, 32'h2000_0000, 0, 0, 1, 0, 0, 16, 0},
		'{10, 4, 0, 0, 0, 0, 3, 0, 0, 0, 1},
		'{11, 4, 0, 0, 0, 0, 3, 0, 0, 0, 1},
		'{12, 4, 0, 0, 0, 0, 3, 0, 0, 0, 1},
		'{13, 4, 0, 0, 15, 7, 1, 0, 0, 3, 0},
		'{13, 4, 0, 0, 15, 8, 3, 0, 0, 0, 1},
		'{13, 4, 0, 0, 14, 0, 3, 0, 0, 0, 1},
		'{14, 4, 0, 0, 0, 0, 3, 0, 0, 0, 1}
	};
	mem_model #(.LAT(3)) u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .req(req), .st(st));
	instruction_cycle_timing DUT (
		.clk(clk), .rst_n(rst_n), .decoded(decoded), .decoded_valid(valid),
		.mem_status(st), .cycle_kind(kind), .accept(accept), .undef_trap(undef_trap),
		.instr_done(instr_done), .mem_request(req), .busy(busy)
	);
	// Free running core clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Count comparisons, report any mismatch at once
	task automatic chk_n(input string nm, input int e, input int g);
		n_tests++;
		if (e != g)
		begin
			$display("Error %s expected %0d seen %0d", nm, e, g);
			err_count++;
		end
	endtask
	task automatic chk_b(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e)
		begin
			$display("Error %s expected %b seen %b", nm, e, g);
			err_count++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Present one descriptor up to the taking edge
	task automatic offer(input row_t r);
		@(posedge clk);
		decoded <= '{cycle_timing_pkg::instr_class_t'(r.c), r.x[2], r.x[1], r.x[0],
			5'(r.n), r.m, 4'(r.cp), 4'(r.cr)};
		valid <= 1'b1;
		@(posedge clk);
	endtask
	// One instruction alone; slow mode looks at the outside traffic instead
	task automatic run(input row_t r);
		logic e;
		logic f;
		logic w;
		logic b;
		offer(r);
		valid <= 1'b0;
		cnt = '{default: 0};
		{e, f, w, b} = 4'h0;
		@(negedge clk);
		chk_b("accept", 1'b1, accept);
		chk_b("undef_trap", r.t[0], undef_trap);
		k = 0;
		do
		begin
			@(negedge clk);
			cnt[kind] += 1;
			e |= req.ext_access;
			f |= req.line_fill;
			w |= req.table_walk;
			b |= req.wbuf_push;
			k++;
		end
		while (instr_done !== 1'b1 && k < 60);
		chk_n("retire", 1, int'(k < 60));
		if (k >= 60)
			print_verdict();
		chk_b("busy", 1'b1, busy);
		chk_n("idle cycles", 0, cnt[0]);
		if (slow)
		begin
			chk_b("external", 1'b1, e);
			chk_b("line fill", 1'b1, f);
			chk_b("table walk", 1'b1, w);
			chk_b("buffer push", 1'b0, b);
		end
		else
		begin
			chk_b("external", 1'b0, e);
			chk_b("buffer push", r.w != 0, b);
			chk_n("fetches", r.f, cnt[1]);
			chk_n("reads", r.r, cnt[2]);
			chk_n("writes", r.w, cnt[3]);
			chk_n("internals", r.i, cnt[4]);
		end
		$display("test class %0d done", r.c);
	endtask
	// Table first, then overlap and slow memory by hand
	initial
	begin
		rst_n = 1'b0;
		slow = 1'b0;
		valid = 1'b0;
		decoded = '0;
		err_count = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[j])
			run(rows[j]);
		// Two stores back to back must leave no idle cycle
		offer(rows[8]);
		{a, d, n, k} = '0;
		while (d < 2 && k < 20)
		begin
			@(negedge clk);
			k++;
			n += int'(kind != cycle_timing_pkg::CYC_IDLE);
			d += int'(instr_done === 1'b1);
			a += int'(accept === 1'b1);
			if (a == 2 && valid)
			begin
				@(posedge clk);
				valid <= 1'b0;
			end
		end
		chk_n("busy cycles", 4, n);
		chk_n("accepts", 2, a);
		$display("test overlap done");
		// Reset in the middle of a long multiply must drop all outputs at once
		offer(rows[19]);
		valid <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk_b("busy", 1'b0, busy);
		chk_b("instr_done", 1'b0, instr_done);
		chk_b("idle kind", 1'b1, kind === cycle_timing_pkg::CYC_IDLE);
		@(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk_b("accept", 1'b0, accept);
		chk_b("busy", 1'b0, busy);
		// The sequencer must take work again right after release
		run(rows[4]);
		$display("test reset done");
		// Misses and a switched-off buffer send traffic outside
		@(posedge clk);
		slow <= 1'b1;
		run(rows[6]);
		run(rows[8]);
		print_verdict();
	end
endmodule
